// ==== design/vcocd_top.sv ====
// VCO calibration control, frequency monitors and clock distribution dividers
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps
`include "vcocd_map.svh"
module vcocd_top
  import vcocd_pkg::*;
#(
  parameter int CAL_CYCLES = `VCOCD_CAL_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic [9:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       ref1_tick,
  input  wire logic       ref2_tick,
  input  wire logic       vco_edge,
  input  wire logic       ext_clk_edge,
  output logic      [3:0] ch_clk_out,
  output logic            sync_active
);
  localparam logic [6:0] WIN_LAST = 7'(`VCOCD_MON_WINDOW_CYC - 1);

  vcocd_top_st_t q_reg;
  vcocd_top_st_t q_next;
  logic          cal_busy;
  logic          cal_done;
  logic [2:0]    mon_tick;
  logic [7:0]    ref_thr;
  logic          pre_src;
  logic [2:0]    pre_last;
  logic [5:0]    div_level;
  logic [5:0]    div_tick;
  logic [5:0]    div_in;

  vcocd_div_if dif [6] ();

  vcocd_cal #(
    .CAL_CYCLES (CAL_CYCLES)
  ) u_cal (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .start       (q_reg.cal_start),
    .ref_tick    (ref1_tick),
    .r_div       (q_reg.rdiv_act),
    .cal_div_sel (q_reg.pll_ctl_act[`VCOCD_CAL_DIV_LSB +: 2]),
    .busy        (cal_busy),
    .done        (cal_done)
  );

  assign mon_tick = {vco_edge, ref2_tick, ref1_tick};
  assign ref_thr  = q_reg.thr_ext ? `VCOCD_REF_THR_EXT : `VCOCD_REF_THR_NORMAL;
  // VCO is the pre-divider source only for code 10
  assign pre_src  = (q_reg.src_act == 2'b10) ? vco_edge : ext_clk_edge;
  // Codes above 4 clamp to ratio 6
  assign pre_last = (q_reg.pre_act > 3'h4) ? 3'h5 : q_reg.pre_act + 3'h1;

  always_comb begin
    q_next           = q_reg;
    q_next.cal_start = 1'b0;
    q_next.rdata     = '0;
    q_next.dist_tick = 1'b0;

    // Register writes land in the shadow set, except the status threshold bit, which takes effect at once
    if (reg_wr) begin
      unique case (reg_addr)
        `VCOCD_ADDR_PLL_CTL: q_next.pll_ctl_sh   = reg_wdata;
        `VCOCD_ADDR_RDIV_LO: q_next.rdiv_sh[7:0] = reg_wdata;
        `VCOCD_ADDR_RDIV_HI: q_next.rdiv_sh[13:8] = reg_wdata[5:0];
        `VCOCD_ADDR_STATUS:  q_next.thr_ext      = reg_wdata[`VCOCD_STAT_THR_BIT];
        `VCOCD_ADDR_PREDIV:  q_next.pre_sh       = reg_wdata[2:0];
        `VCOCD_ADDR_SRC_SEL: q_next.src_sh       = reg_wdata[1:0];
        `VCOCD_ADDR_UPDATE: begin
          if (reg_wdata[`VCOCD_UPDATE_BIT]) begin
            q_next.pll_ctl_act = q_reg.pll_ctl_sh;
            q_next.rdiv_act    = q_reg.rdiv_sh;
            q_next.src_act     = q_reg.src_sh;
            q_next.pre_act     = q_reg.pre_sh;
            q_next.cyc_act     = q_reg.cyc_sh;
            q_next.ctl_act     = q_reg.ctl_sh;
            q_next.opt_act     = q_reg.opt_sh;
            // Only the applied zero-to-one edge of the start bit launches a run
            q_next.cal_start   = q_reg.pll_ctl_sh[`VCOCD_CAL_START_BIT] &&
                                 !q_reg.pll_ctl_act[`VCOCD_CAL_START_BIT];
          end
        end
        default: begin
          for (int k = 0; k < 6; k++) begin
            if (reg_addr == `VCOCD_ADDR_DIV_BASE + 10'(k) * `VCOCD_DIV_STRIDE) begin
              q_next.cyc_sh[k] = reg_wdata;
            end
            if (reg_addr == `VCOCD_ADDR_DIV_BASE + 10'(k) * `VCOCD_DIV_STRIDE + 10'h001) begin
              q_next.ctl_sh[k] = reg_wdata;
            end
            if (reg_addr == `VCOCD_ADDR_DIV_BASE + 10'(k) * `VCOCD_DIV_STRIDE + 10'h002) begin
              q_next.opt_sh[k] = reg_wdata;
            end
          end
        end
      endcase
    end

    // Reads answer one cycle later; unmapped addresses read zero
    if (reg_rd) begin
      unique case (reg_addr)
        `VCOCD_ADDR_PLL_CTL: q_next.rdata = q_reg.pll_ctl_sh;
        `VCOCD_ADDR_RDIV_LO: q_next.rdata = q_reg.rdiv_sh[7:0];
        `VCOCD_ADDR_RDIV_HI: q_next.rdata = {2'b00, q_reg.rdiv_sh[13:8]};
        `VCOCD_ADDR_STATUS: begin
          q_next.rdata[`VCOCD_STAT_THR_BIT]  = q_reg.thr_ext;
          q_next.rdata[`VCOCD_STAT_DONE_BIT] = cal_done;
          q_next.rdata[`VCOCD_STAT_VCO_BIT]  = q_reg.mon_low[2];
          q_next.rdata[`VCOCD_STAT_REF2_BIT] = q_reg.mon_low[1];
          q_next.rdata[`VCOCD_STAT_REF1_BIT] = q_reg.mon_low[0];
          q_next.rdata[`VCOCD_STAT_BUSY_BIT] = cal_busy;
        end
        `VCOCD_ADDR_PREDIV:  q_next.rdata = {5'h00, q_reg.pre_sh};
        `VCOCD_ADDR_SRC_SEL: q_next.rdata = {6'h00, q_reg.src_sh};
        `VCOCD_ADDR_UPDATE:  q_next.rdata = 8'h00;
        default: begin
          for (int k = 0; k < 6; k++) begin
            if (reg_addr == `VCOCD_ADDR_DIV_BASE + 10'(k) * `VCOCD_DIV_STRIDE) begin
              q_next.rdata = q_reg.cyc_sh[k];
            end
            if (reg_addr == `VCOCD_ADDR_DIV_BASE + 10'(k) * `VCOCD_DIV_STRIDE + 10'h001) begin
              q_next.rdata = q_reg.ctl_sh[k];
            end
            if (reg_addr == `VCOCD_ADDR_DIV_BASE + 10'(k) * `VCOCD_DIV_STRIDE + 10'h002) begin
              q_next.rdata = q_reg.opt_sh[k];
            end
          end
        end
      endcase
    end

    // Frequency monitors count edges over a fixed window of system clocks
    for (int m = 0; m < 3; m++) begin
      if (mon_tick[m] && q_reg.mon_cnt[m] != 8'hff) begin
        q_next.mon_cnt[m] = q_reg.mon_cnt[m] + 8'h01;
      end
    end
    if (q_reg.win_cnt == WIN_LAST) begin
      q_next.win_cnt    = '0;
      q_next.mon_low[0] = q_reg.mon_cnt[0] < ref_thr;
      q_next.mon_low[1] = q_reg.mon_cnt[1] < ref_thr;
      q_next.mon_low[2] = q_reg.mon_cnt[2] < `VCOCD_VCO_THR;
      q_next.mon_cnt    = '0;
    end else begin
      q_next.win_cnt = q_reg.win_cnt + 7'h01;
    end

    // Source select and pre-divider; code 11 feeds nothing
    unique case (q_reg.src_act)
      2'b01: q_next.dist_tick = ext_clk_edge;
      2'b11: q_next.dist_tick = 1'b0;
      default: begin
        if (pre_src) begin
          if (q_reg.pre_cnt >= pre_last) begin
            q_next.pre_cnt   = '0;
            q_next.dist_tick = 1'b1;
          end else begin
            q_next.pre_cnt = q_reg.pre_cnt + 3'h1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      q_reg             <= '0;
      q_reg.pll_ctl_sh  <= `VCOCD_RST_PLL_CTL;
      q_reg.pll_ctl_act <= `VCOCD_RST_PLL_CTL;
      q_reg.rdiv_sh     <= `VCOCD_RST_RDIV;
      q_reg.rdiv_act    <= `VCOCD_RST_RDIV;
      q_reg.src_sh      <= `VCOCD_RST_SRC;
      q_reg.src_act     <= `VCOCD_RST_SRC;
      q_reg.pre_sh      <= `VCOCD_RST_PREDIV;
      q_reg.pre_act     <= `VCOCD_RST_PREDIV;
      q_reg.cyc_sh      <= {6{`VCOCD_RST_DIV_CYC}};
      q_reg.cyc_act     <= {6{`VCOCD_RST_DIV_CYC}};
      q_reg.ctl_sh      <= {6{`VCOCD_RST_DIV_CTL}};
      q_reg.ctl_act     <= {6{`VCOCD_RST_DIV_CTL}};
      q_reg.opt_sh      <= {6{`VCOCD_RST_DIV_OPT}};
      q_reg.opt_act     <= {6{`VCOCD_RST_DIV_OPT}};
    end else begin
      q_reg <= q_next;
    end
  end

  // Dividers 3 and 5 are the second stage of the cascaded channels
  assign div_in = {div_tick[4], q_reg.dist_tick, div_tick[2], {3{q_reg.dist_tick}}};

  for (genvar k = 0; k < 6; k++) begin : g_div
    assign dif[k].high_cnt                = q_reg.cyc_act[k][3:0];
    assign dif[k].low_cnt                 = q_reg.cyc_act[k][7:4];
    assign dif[k].phase                   = q_reg.ctl_act[k][4:0];
    assign dif[k].bypass                  = q_reg.ctl_act[k][`VCOCD_DIV_BYPASS_BIT];
    assign dif[k].duty_correction_disable = q_reg.opt_act[k][`VCOCD_DIV_DUTY_CORRECTION_DISABLE_BIT];
    assign dif[k].start_high              = q_reg.opt_act[k][`VCOCD_DIV_STHIGH_BIT];
    assign dif[k].hold                    = cal_busy;
    assign dif[k].in_tick                 = div_in[k];
    assign div_level[k]                   = dif[k].out_level;
    assign div_tick[k]                    = dif[k].out_tick;

    vcocd_chdiv u_div (
      .clk_sys (clk_sys),
      .reset   (reset),
      .dv      (dif[k])
    );
  end

  assign ch_clk_out  = {div_level[5], div_level[3], div_level[1], div_level[0]};
  assign sync_active = cal_busy;
  assign reg_rdata   = q_reg.rdata;
endmodule : vcocd_top

// ==== design/vcocd_map.svh ====
// Register offsets, field positions, reset values and timing counts of the clock control block
`ifndef VCOCD_MAP_SVH
`define VCOCD_MAP_SVH

`define VCOCD_ADDR_RDIV_LO    10'h011
`define VCOCD_ADDR_RDIV_HI    10'h012
`define VCOCD_ADDR_PLL_CTL    10'h018
`define VCOCD_ADDR_STATUS     10'h01f
`define VCOCD_ADDR_DIV_BASE   10'h190
`define VCOCD_DIV_STRIDE      10'h006
`define VCOCD_ADDR_PREDIV     10'h1e0
`define VCOCD_ADDR_SRC_SEL    10'h1e1
`define VCOCD_ADDR_UPDATE     10'h232

`define VCOCD_CAL_START_BIT   0
`define VCOCD_CAL_DIV_LSB     1
`define VCOCD_STAT_BUSY_BIT   0
`define VCOCD_STAT_REF1_BIT   1
`define VCOCD_STAT_REF2_BIT   2
`define VCOCD_STAT_VCO_BIT    3
`define VCOCD_STAT_DONE_BIT   6
`define VCOCD_STAT_THR_BIT    7
`define VCOCD_UPDATE_BIT      0
`define VCOCD_DIV_BYPASS_BIT  7
`define VCOCD_DIV_DUTY_CORRECTION_DISABLE_BIT  0
`define VCOCD_DIV_STHIGH_BIT  2

`define VCOCD_RST_PLL_CTL     8'h00
`define VCOCD_RST_RDIV        14'h0001
`define VCOCD_RST_SRC         2'h0
`define VCOCD_RST_PREDIV      3'h0
`define VCOCD_RST_DIV_CYC     8'h00
`define VCOCD_RST_DIV_CTL     8'h00
`define VCOCD_RST_DIV_OPT     8'h00

`define VCOCD_CAL_CYCLES      4400
`define VCOCD_CLK_PERIOD_NS   10
`define VCOCD_MON_WINDOW_NS   1000
`define VCOCD_MON_WINDOW_CYC  (`VCOCD_MON_WINDOW_NS / `VCOCD_CLK_PERIOD_NS)
`define VCOCD_REF_THR_NORMAL  8'h08
`define VCOCD_REF_THR_EXT     8'h02
`define VCOCD_VCO_THR         8'h32

`endif

// ==== design/vcocd_pkg.sv ====
// Types of the calibration and clock distribution block
package vcocd_pkg;

  typedef enum logic {CAL_IDLE, CAL_RUN} vcocd_cal_state_t;

  typedef struct packed {
    vcocd_cal_state_t state;
    logic [13:0]      r_cnt;
    logic [3:0]       c_cnt;
    logic [12:0]      n_cnt;
    logic             done;
  } vcocd_cal_st_t;

  typedef struct packed {
    logic [5:0] cnt;
    logic [5:0] dly;
    logic       lvl;
    logic       tick;
  } vcocd_div_st_t;

  typedef struct packed {
    logic [7:0]       pll_ctl_sh;
    logic [7:0]       pll_ctl_act;
    logic [13:0]      rdiv_sh;
    logic [13:0]      rdiv_act;
    logic             thr_ext;
    logic [1:0]       src_sh;
    logic [1:0]       src_act;
    logic [2:0]       pre_sh;
    logic [2:0]       pre_act;
    logic [5:0][7:0]  cyc_sh;
    logic [5:0][7:0]  cyc_act;
    logic [5:0][7:0]  ctl_sh;
    logic [5:0][7:0]  ctl_act;
    logic [5:0][7:0]  opt_sh;
    logic [5:0][7:0]  opt_act;
    logic             cal_start;
    logic [7:0]       rdata;
    logic [2:0]       pre_cnt;
    logic             dist_tick;
    logic [6:0]       win_cnt;
    logic [2:0][7:0]  mon_cnt;
    logic [2:0]       mon_low;
  } vcocd_top_st_t;

endpackage : vcocd_pkg

// ==== design/vcocd_div_if.sv ====
// Settings and outputs of one channel divider
`timescale 1ns/10ps
interface vcocd_div_if;
  logic [3:0] high_cnt;
  logic [3:0] low_cnt;
  logic [4:0] phase;
  logic       bypass;
  logic       duty_correction_disable;
  logic       start_high;
  logic       hold;
  logic       in_tick;
  logic       out_level;
  logic       out_tick;

  modport ctl (output high_cnt, low_cnt, phase, bypass, duty_correction_disable, start_high, hold, in_tick,
               input out_level, out_tick);
  modport div (input high_cnt, low_cnt, phase, bypass, duty_correction_disable, start_high, hold, in_tick,
               output out_level, out_tick);
endinterface : vcocd_div_if

// ==== design/vcocd_cal.sv ====
// VCO calibration sequencer running on divided reference edges
`timescale 1ns/10ps
`include "vcocd_map.svh"
module vcocd_cal
  import vcocd_pkg::*;
#(
  parameter int CAL_CYCLES = `VCOCD_CAL_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        start,
  input  wire logic        ref_tick,
  input  wire logic [13:0] r_div,
  input  wire logic [1:0]  cal_div_sel,
  output logic             busy,
  output logic             done
);
  localparam logic [12:0] CAL_LAST = 13'(CAL_CYCLES - 1);

  vcocd_cal_st_t q_reg;
  vcocd_cal_st_t q_next;
  logic [13:0]   r_last;
  logic [3:0]    c_last;

  // R of zero behaves as one
  assign r_last = (r_div == 14'h0000) ? 14'h0000 : r_div - 14'h0001;
  assign c_last = 4'((5'h02 << cal_div_sel) - 5'h01);

  always_comb begin
    q_next = q_reg;
    unique case (q_reg.state)
      CAL_IDLE: begin
        if (start) begin
          q_next.state = CAL_RUN;
          q_next.done  = 1'b0;
          q_next.r_cnt = '0;
          q_next.c_cnt = '0;
          q_next.n_cnt = '0;
        end
      end
      CAL_RUN: begin
        // No reference edges means no progress
        if (ref_tick) begin
          if (q_reg.r_cnt == r_last) begin
            q_next.r_cnt = '0;
            if (q_reg.c_cnt == c_last) begin
              q_next.c_cnt = '0;
              if (q_reg.n_cnt == CAL_LAST) begin
                q_next.state = CAL_IDLE;
                q_next.done  = 1'b1;
              end else begin
                q_next.n_cnt = q_reg.n_cnt + 13'h0001;
              end
            end else begin
              q_next.c_cnt = q_reg.c_cnt + 4'h1;
            end
          end else begin
            q_next.r_cnt = q_reg.r_cnt + 14'h0001;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      q_reg <= '{state: CAL_IDLE, default: '0};
    end else begin
      q_reg <= q_next;
    end
  end

  assign busy = (q_reg.state == CAL_RUN);
  assign done = q_reg.done;
endmodule : vcocd_cal

// ==== design/vcocd_chdiv.sv ====
// One channel divider counted in input half-cycles
`timescale 1ns/10ps
module vcocd_chdiv
  import vcocd_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic reset,
  vcocd_div_if.div  dv
);
  vcocd_div_st_t q_reg;
  vcocd_div_st_t q_next;
  logic [5:0]    div_d;
  logic          dcc_on;
  logic [5:0]    hi_len;
  logic [5:0]    lo_len;
  logic [5:0]    cur_len;

  // Each in_tick is one input clock edge, so half-cycles give exact 50 percent for odd D
  assign div_d   = 6'(dv.high_cnt) + 6'(dv.low_cnt) + 6'h02;
  assign dcc_on  = !dv.duty_correction_disable &&
                   ((dv.low_cnt == dv.high_cnt) || (5'(dv.low_cnt) == 5'(dv.high_cnt) + 5'h01));
  assign hi_len  = dcc_on ? div_d : {1'b0, dv.high_cnt, 1'b0} + 6'h02;
  assign lo_len  = dcc_on ? div_d : {1'b0, dv.low_cnt, 1'b0} + 6'h02;
  assign cur_len = q_reg.lvl ? hi_len : lo_len;

  always_comb begin
    q_next      = q_reg;
    q_next.tick = 1'b0;
    if (dv.hold) begin
      q_next.lvl = dv.start_high;
      q_next.cnt = '0;
      q_next.dly = {dv.phase, 1'b0};
    end else if (dv.in_tick) begin
      if (dv.bypass) begin
        q_next.lvl  = !q_reg.lvl;
        q_next.tick = 1'b1;
      end else if (q_reg.dly != 6'h00) begin
        q_next.dly = q_reg.dly - 6'h01;
      end else if (q_reg.cnt + 6'h01 == cur_len) begin
        q_next.cnt  = '0;
        q_next.lvl  = !q_reg.lvl;
        q_next.tick = 1'b1;
      end else begin
        q_next.cnt = q_reg.cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign dv.out_level = q_reg.lvl;
  assign dv.out_tick  = q_reg.tick;
endmodule : vcocd_chdiv

// ==== sim/vcocd_top_monitor.sv ====
// Port checker of the calibration and clock distribution block
`timescale 1ns/10ps
`include "vcocd_map.svh"
module vcocd_top_monitor
  import vcocd_pkg::*;
#(
  parameter int CAL_CYCLES = 8
) (
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       ref1_tick,
  input wire logic       ref2_tick,
  input wire logic       vco_edge,
  input wire logic       ext_clk_edge,
  input wire logic [3:0] ch_clk_out,
  input wire logic       sync_active
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        sync_q;
    logic        done_seen;
  } vcocd_chk_st_t;
  vcocd_chk_st_t st_reg;
  vcocd_chk_st_t st_next;
  logic          st_rd;
  assign st_rd = reg_rd && reg_addr == `VCOCD_ADDR_STATUS;
  always_comb begin
    st_next = st_reg;
    st_next.sync_q = sync_active;
    st_next.cnt = sync_active ? st_reg.cnt + 16'(ref1_tick) : 16'h0000;
    if (st_reg.sync_q && !sync_active) begin
      st_next.done_seen = 1'b1;
    end else if (sync_active) begin
      st_next.done_seen = 1'b0;
    end
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  chk_busy_read: assert property (st_rd && sync_active |=> !reg_rdata[6] && reg_rdata[0])
    else $error("status wrong during calibration");
  chk_done_read: assert property (st_rd && !sync_active && st_reg.done_seen |=> reg_rdata[6])
    else $error("done bit low after calibration");
  chk_start_cause: assert property ($rose(sync_active) |->
    $past(reg_wr && reg_addr == `VCOCD_ADDR_UPDATE && reg_wdata[0], 2))
    else $error("calibration began without an update");
  chk_end_on_tick: assert property ($fell(sync_active) |-> $past(ref1_tick))
    else $error("calibration ended without a reference edge");
  chk_cal_length: assert property ($fell(sync_active) |-> st_reg.cnt >= 16'(2 * CAL_CYCLES))
    else $error("calibration too short");
  chk_sync_hold: assert property (sync_active[*4] |-> $stable(ch_clk_out))
    else $error("outputs moved during calibration");
  chk_no_edge_hold: assert property ((!ext_clk_edge && !vco_edge && !sync_active && !reg_wr)[*6]
    |-> $stable(ch_clk_out))
    else $error("outputs moved without source edges");
  cov_cal_end: cover property ($fell(sync_active));
  cov_busy_read: cover property (st_rd && sync_active);
  cov_ch0_rise: cover property ($rose(ch_clk_out[0]));
endmodule : vcocd_top_monitor
bind vcocd_top vcocd_top_monitor #(.CAL_CYCLES(CAL_CYCLES)) vcocd_top_monitor_i (
  .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref1_tick(ref1_tick),
  .ref2_tick(ref2_tick), .vco_edge(vco_edge), .ext_clk_edge(ext_clk_edge),
  .ch_clk_out(ch_clk_out), .sync_active(sync_active));

// ==== sim/vcocd_host.sv ====
// Host model: register port master and calibration start sequence
`timescale 1ns/10ps
`include "vcocd_map.svh"
module vcocd_host (
  input  wire logic       clk_sys,
  output logic      [9:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr  = 10'h000;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  // The reference runs before any start
  task automatic cal_go(input logic [1:0] sel, input logic first);
    if (!first) begin
      wr(`VCOCD_ADDR_PLL_CTL, {5'h00, sel, 1'b0});
      wr(`VCOCD_ADDR_UPDATE, 8'h01);
    end
    wr(`VCOCD_ADDR_PLL_CTL, {5'h00, sel, 1'b1});
    wr(`VCOCD_ADDR_UPDATE, 8'h01);
  endtask : cal_go
endmodule : vcocd_host

// ==== sim/test_vco_cal_and_clock_distribution.sv ====
// Self-checking bench of the calibration and clock distribution block
`timescale 1ns/10ps
`include "vcocd_map.svh"
module test_vco_cal_and_clock_distribution;
  import vcocd_pkg::*;
  localparam int CAL = 8;
  // Fields: source, pre-divider code, M, N, duty correction off
  localparam logic [19:0] DT [5] = '{20'h10211, 20'h10210, 20'h01000, 20'h20220, 20'h10ff1};
  logic        clk_sys      = 1'b0;
  logic        reset        = 1'b1;
  logic        ref1_tick    = 1'b0;
  logic        ref2_tick    = 1'b0;
  logic        vco_edge     = 1'b0;
  logic        ext_clk_edge = 1'b0;
  logic        ref_on       = 1'b1;
  logic        vco_run      = 1'b1;
  logic        ext_on       = 1'b0;
  logic [31:0] seed         = 32'h7d87b554;
  logic [9:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic [3:0]  ch_clk_out;
  logic        sync_active;
  logic [7:0]  mdl [int];
  int          bad_count    = 0;
  int          n_tests      = 0;
  int          ticks        = 0;
  always #5 clk_sys = ~clk_sys;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  always @(posedge clk_sys) begin
    seed         <= lfsr(seed);
    ref1_tick    <= ref_on & seed[0];
    ref2_tick    <= ref_on & seed[5];
    vco_edge     <= vco_run & ~vco_edge;
    ext_clk_edge <= ext_on;
    if (sync_active) begin
      ticks <= ticks + int'(ref1_tick);
    end
  end
  vcocd_host vcocd_host_i (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  vcocd_top #(.CAL_CYCLES(CAL)) vcocd_top_i (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ref1_tick(ref1_tick), .ref2_tick(ref2_tick), .vco_edge(vco_edge), .ext_clk_edge(ext_clk_edge),
    .ch_clk_out(ch_clk_out), .sync_active(sync_active));
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim
  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask : check
  task automatic wr_m(input logic [9:0] a, input logic [7:0] d);
    vcocd_host_i.wr(a, d);
    mdl[int'(a)] = d;
  endtask : wr_m
  task automatic rd_c(input logic [9:0] a);
    logic [7:0] d;
    vcocd_host_i.rd(a, d);
    check("register", {8'h00, mdl.exists(int'(a)) ? mdl[int'(a)] : 8'h00}, {8'h00, d});
  endtask : rd_c
  task automatic stat(input logic [7:0] msk, input logic [7:0] e);
    logic [7:0] d;
    vcocd_host_i.rd(`VCOCD_ADDR_STATUS, d);
    check("status", {8'h00, e}, {8'h00, d & msk});
  endtask : stat
  task automatic step(inout int k);
    @(posedge clk_sys);
    #1;
    k++;
  endtask : step
  task automatic stuck(input string nm);
    bad_count++;
    $display("BAD %s wait ran out", nm);
    end_sim();
  endtask : stuck
  task automatic wait_sync(input logic lvl, input int lim);
    int k;
    k = 0;
    while (sync_active !== lvl && k < lim) step(k);
    if (sync_active !== lvl) stuck("sync_active");
  endtask : wait_sync
  // Counts one whole high and one whole low phase after a fresh rise
  task automatic meas(input int b, output int hi, output int lo);
    int k;
    int k0;
    k = 0;
    while (ch_clk_out[b] !== 1'b0 && k < 300) step(k);
    while (ch_clk_out[b] !== 1'b1 && k < 300) step(k);
    k0 = k;
    while (ch_clk_out[b] === 1'b1 && k < 300) step(k);
    hi = k - k0;
    k0 = k;
    while (ch_clk_out[b] === 1'b0 && k < 300) step(k);
    lo = k - k0;
    if (k >= 300) stuck("divider");
  endtask : meas
  initial begin
    int hi, lo, mult, eh, el, n, m;
    logic dcc;
    logic [7:0] dv;
    mdl[int'(`VCOCD_ADDR_RDIV_LO)] = 8'h01;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    rd_c(`VCOCD_ADDR_PLL_CTL);
    rd_c(`VCOCD_ADDR_RDIV_LO);
    rd_c(`VCOCD_ADDR_SRC_SEL);
    rd_c(`VCOCD_ADDR_UPDATE);
    rd_c(10'h3ff);
    stat(8'h41, 8'h00);
    for (int i = 2; i < 6; i++) begin
      wr_m(`VCOCD_ADDR_DIV_BASE + `VCOCD_DIV_STRIDE * 10'(i), seed[7:0]);
      rd_c(`VCOCD_ADDR_DIV_BASE + `VCOCD_DIV_STRIDE * 10'(i));
    end
    for (int s = 0; s < 4; s++) begin
      wr_m(`VCOCD_ADDR_RDIV_LO, 8'(s + 1));
      // Alternate the start level of divider 0 so the held state is seen both ways
      wr_m(`VCOCD_ADDR_DIV_BASE + 10'h002, 8'((s % 2) * 4));
      ticks = 0;
      vcocd_host_i.cal_go(2'(s), s == 0);
      wait_sync(1'b1, 10);
      stat(8'h41, 8'h01);
      check("held level", 16'(s % 2), {15'h0000, ch_clk_out[0]});
      if (s == 3) begin
        ref_on = 1'b0;
        #600;
        check("stalled calibration", 16'h0001, {15'h0000, sync_active});
        ref_on = 1'b1;
      end
      wait_sync(1'b0, 4000);
      check("calibration ticks", 16'(CAL * (s + 1) * (2 << s)), 16'(ticks));
      stat(8'h41, 8'h40);
    end
    // Start bit already set: a plain update or a divider change must not restart
    vcocd_host_i.wr(`VCOCD_ADDR_UPDATE, 8'h01);
    wr_m(`VCOCD_ADDR_RDIV_LO, 8'h02);
    vcocd_host_i.wr(`VCOCD_ADDR_UPDATE, 8'h01);
    #200;
    check("no restart", 16'h0000, {15'h0000, sync_active});
    ext_on = 1'b1;
    wr_m(`VCOCD_ADDR_DIV_BASE + `VCOCD_DIV_STRIDE + 10'h001, 8'h80);
    // Second stages bypassed: the cascade period then shows the random first stage
    wr_m(`VCOCD_ADDR_DIV_BASE + `VCOCD_DIV_STRIDE * 10'h003 + 10'h001, 8'h80);
    wr_m(`VCOCD_ADDR_DIV_BASE + `VCOCD_DIV_STRIDE * 10'h005 + 10'h001, 8'h80);
    for (int j = 0; j < 5; j++) begin
      wr_m(`VCOCD_ADDR_SRC_SEL, 8'(DT[j][17:16]));
      wr_m(`VCOCD_ADDR_PREDIV, 8'(DT[j][14:12]));
      wr_m(`VCOCD_ADDR_DIV_BASE, DT[j][11:4]);
      wr_m(`VCOCD_ADDR_DIV_BASE + 10'h002, 8'(DT[j][0]));
      vcocd_host_i.wr(`VCOCD_ADDR_UPDATE, 8'h01);
      #700;
      n = int'(DT[j][7:4]);
      m = int'(DT[j][11:8]);
      dcc = !DT[j][0] && (m == n || m == n + 1);
      mult = DT[j][17:16] == 2'h1 ? 1 : int'(DT[j][14:12]) + 2;
      mult = DT[j][17:16] == 2'h2 ? mult * 2 : mult;
      eh = dcc ? n + m + 2 : 2 * (n + 1);
      el = dcc ? n + m + 2 : 2 * (m + 1);
      meas(0, hi, lo);
      check("ch0 high", 16'(eh * mult), 16'(hi));
      check("ch0 low", 16'(el * mult), 16'(lo));
      meas(1, hi, lo);
      check("ch1 bypass", 16'(mult), 16'(hi));
      if (j == 0) begin
        for (int c = 2; c < 4; c++) begin
          dv = mdl[int'(`VCOCD_ADDR_DIV_BASE + `VCOCD_DIV_STRIDE * 10'(2 * c - 2))];
          meas(c, hi, lo);
          check("cascade period", 16'(2 * (int'(dv[7:4]) + int'(dv[3:0]) + 2) * mult), 16'(hi + lo));
        end
      end
    end
    ext_on = 1'b0;
    stat(8'h06, 8'h00);
    wr_m(`VCOCD_ADDR_STATUS, 8'h80);
    stat(8'h80, 8'h80);
    ref_on = 1'b0;
    vco_run = 1'b0;
    #2500;
    stat(8'h0e, 8'h0e);
    end_sim();
  end
endmodule : test_vco_cal_and_clock_distribution
